/* rtl/srr_defs.svh */
// Constants for the suspend, resume and processor-reset controller.
// Assumes a single 250 MHz core clock that stops while suspended.
// Summary of operation
// R01: Suspend after 3 ms without bus activity
// R02: Suspend raises the USB interrupt request
// R03: Firmware powers off externals, then sets power-down
// R04: Power-down bit puts processor into idle
// R05: Power-down stops oscillator and PLL
// R06: Bus activity or wakeup pin wakes device
// R07: Wake restarts clocks, waits for stable clocks
// R08: Stable clocks raise high-priority resume interrupt
// R09: Processor continues after the power-down instruction
// R10: Power-down is bit 0 at 0x87
// R11: Flags 0x91, enables 0xE8, priorities 0xF8 bits 0-3
// R12: Interrupt six flag, enable, priority bits
// R13: Wakeup flag bit 4, enable bit 5 at 0xD8
// R14: Processor reset follows host register bit
// R15: Held in reset until host clears bit
// R16: Non-volatile boot releases reset automatically
// R17: Twenty-one sources share the USB interrupt line
// R18: Wake capture works with clocks stopped
`ifndef SRR_DEFS_SVH
`define SRR_DEFS_SVH

// Special-function addresses
`define SRR_ADDR_POWER_CONTROL 8'h87
`define SRR_ADDR_FLAGS 8'h91
`define SRR_ADDR_CONTROL 8'hd8
`define SRR_ADDR_ENABLES 8'he8
`define SRR_ADDR_PRIORITY 8'hf8

// Field positions
`define SRR_PD_BIT 0
`define SRR_FLAGS_LSB 4
`define SRR_X6_FLAG_BIT 3
`define SRR_WAKE_FLAG_BIT 4
`define SRR_WAKE_EN_BIT 5
`define SRR_X6_EN_BIT 4
`define SRR_X6_PRIO_BIT 4

// Reset values
`define SRR_SFR_RESET 8'h00

// Timing
`define SRR_CLK_MHZ 250
`define SRR_SUSP_IDLE_US 3000
`define SRR_SUSP_IDLE_CYC (`SRR_SUSP_IDLE_US * `SRR_CLK_MHZ)
`define SRR_USB_SOURCES 21
`define SRR_STRAP_WAIT 2'h3

`endif

/* rtl/srr_pkg.sv */
// Types for the suspend, resume and processor-reset controller.
// Assumes the constants header is included by the design files.
package srr_pkg;

	// Power sequence states, one-hot
	typedef enum logic [3:0]
	{
		SRR_RUN = 4'b0001,
		SRR_SUSPEND = 4'b0010,
		SRR_WAIT_CLK = 4'b0100,
		SRR_RESUME = 4'b1000
	} srr_state_e;

endpackage : srr_pkg

/* rtl/srr_wake_capture.sv */
// Clockless capture of one wake event.
// Assumes the event pin may toggle while every internal clock is stopped.
module srr_wake_capture #(
	parameter bit ACTIVE_LOW = 1'b0
) (
	// Event pin
	input wire logic evt_i,
	// Clear from the core clock domain
	input wire logic clr_i,
	// Captured wake
	output logic wake_o
);

	logic evt_edge;

	// Pin edge clocks the latch, so no running clock is needed
	assign evt_edge = ACTIVE_LOW ? ~evt_i : evt_i;

	// Clear acts without a clock; it only ever loads a constant
	always_ff @(posedge evt_edge or posedge clr_i) // [R18]
	begin
		if (clr_i)
			wake_o <= 1'b0;
		else
			wake_o <= 1'b1;
	end

endmodule : srr_wake_capture

/* rtl/srr_power_ctrl.sv */
// Suspend, resume and processor-reset control with its interrupt registers.
// Assumes the core clock stops whenever osc_stop_o is high and that
// special-function writes arrive as single-cycle strobes on clk_i.
`include "srr_defs.svh"

module srr_power_ctrl #(
	parameter int SUSPEND_CYCLES = `SRR_SUSP_IDLE_CYC,
	parameter int USB_SOURCES = `SRR_USB_SOURCES
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Special-function register port
	input wire logic [7:0] sfr_addr_i,
	input wire logic sfr_wr_i,
	input wire logic [7:0] sfr_wdata_i,
	output logic [7:0] sfr_rdata_o,
	// Bus and pins
	input wire logic bus_activity_i,
	input wire logic wakeup_n_i,
	input wire logic clk_stable_i,
	input wire logic boot_nvm_i,
	// Interrupt sources and acknowledges
	input wire logic [USB_SOURCES-2:0] usb_src_i,
	input wire logic suspend_ack_i,
	input wire logic [3:0] ext_evt_i,
	input wire logic resume_ack_i,
	// Host reset-control bit
	input wire logic host_reset_we_i,
	input wire logic host_reset_bit_i,
	// To the processor and clock generator
	output logic usb_interrupt_request_o,
	output logic [4:0] ext_irq_o,
	output logic [4:0] ext_prio_o,
	output logic wake_irq_o,
	output logic resume_irq_o,
	output logic cpu_idle_o,
	output logic osc_stop_o,
	output logic cpu_reset_o,
	output logic [3:0] state_o
);
	import srr_pkg::*;

	localparam int CW = $clog2(SUSPEND_CYCLES + 1);
	localparam logic [CW-1:0] IDLE_LAST = CW'(SUSPEND_CYCLES - 1);

	srr_state_e state;
	srr_state_e next_state;
	logic [7:0] power_control_sfr;
	logic [3:0] ext_int_flags;
	logic [7:0] ext_int_control;
	logic [7:0] ext_int_enables;
	logic [7:0] ext_int_priority;
	logic act_s1, act_s;
	logic bw_s1, bw_s;
	logic rw_s1, rw_s;
	logic stab_s1, stab_s;
	logic boot_s1, boot_s;
	logic [CW-1:0] idle_cnt;
	logic idle_hit;
	logic suspend_evt;
	logic susp_pend;
	logic usb_req_d;
	logic wake_clr;
	logic bus_wake;
	logic rem_wake;
	logic wake_any;
	logic [1:0] strap_cnt;
	logic wr_pc, wr_fl, wr_ct, wr_en, wr_pr;
	logic pd_req;

	// Register write decode
	assign wr_pc = sfr_wr_i && (sfr_addr_i == `SRR_ADDR_POWER_CONTROL); // [R10]
	assign wr_fl = sfr_wr_i && (sfr_addr_i == `SRR_ADDR_FLAGS); // [R11]
	assign wr_ct = sfr_wr_i && (sfr_addr_i == `SRR_ADDR_CONTROL);
	assign wr_en = sfr_wr_i && (sfr_addr_i == `SRR_ADDR_ENABLES);
	assign wr_pr = sfr_wr_i && (sfr_addr_i == `SRR_ADDR_PRIORITY);
	assign pd_req = wr_pc && sfr_wdata_i[`SRR_PD_BIT] && (state == SRR_RUN);

	// Wake capture on bus activity and on the remote-wakeup pin
	srr_wake_capture #(
		.ACTIVE_LOW(1'b0)
	) u_bus_wake (
		.evt_i(bus_activity_i),
		.clr_i(wake_clr),
		.wake_o(bus_wake)
	); // [R06] [R18]

	srr_wake_capture #(
		.ACTIVE_LOW(1'b1)
	) u_rem_wake (
		.evt_i(wakeup_n_i),
		.clr_i(wake_clr),
		.wake_o(rem_wake)
	); // [R06] [R18]

	assign wake_any = bus_wake | rem_wake;

	// Two-stage synchronisers for everything outside the clock domain
	always_ff @(posedge clk_i)
	begin
		act_s1 <= bus_activity_i;
		act_s <= act_s1;
		bw_s1 <= bus_wake;
		bw_s <= bw_s1;
		rw_s1 <= rem_wake;
		rw_s <= rw_s1;
		stab_s1 <= clk_stable_i;
		stab_s <= stab_s1;
		boot_s1 <= boot_nvm_i;
		boot_s <= boot_s1;
	end

	// Bus idle timer, restarted by any activity
	always_ff @(posedge clk_i)
	begin
		if (rst_i || act_s || state != SRR_RUN)
		begin
			idle_cnt <= '0;
			idle_hit <= 1'b0;
		end
		else if (!idle_hit)
		begin
			if (idle_cnt == IDLE_LAST)
				idle_hit <= 1'b1; // [R01]
			else
				idle_cnt <= idle_cnt + 1'b1;
		end
	end

	// One pulse per idle period, not per cycle of silence
	assign suspend_evt = (idle_cnt == IDLE_LAST) && !idle_hit && !act_s &&
		(state == SRR_RUN); // [R01]

	// Suspend pending; a new detection beats a same-cycle acknowledge
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			susp_pend <= 1'b0;
		else if (suspend_evt)
			susp_pend <= 1'b1; // [R02]
		else if (suspend_ack_i)
			susp_pend <= 1'b0;
	end

	// Shared USB request line: suspend plus the other twenty sources
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			usb_interrupt_request_o <= 1'b0;
			usb_req_d <= 1'b0;
		end
		else
		begin
			usb_interrupt_request_o <= susp_pend | (|usb_src_i); // [R02] [R17]
			usb_req_d <= usb_interrupt_request_o;
		end
	end

	// Power sequence
	always_comb
	begin
		next_state = state;
		unique case (state)
			SRR_RUN:
				if (pd_req)
					next_state = SRR_SUSPEND; // [R04]
			SRR_SUSPEND:
				// Wakes still in the synchroniser while latches clear are stale
				if ((bw_s || rw_s) && !wake_clr)
					next_state = SRR_WAIT_CLK; // [R06]
			SRR_WAIT_CLK:
				if (stab_s)
					next_state = SRR_RESUME; // [R07]
			SRR_RESUME:
				if (resume_ack_i)
					next_state = SRR_RUN; // [R09]
			default:
				next_state = SRR_RUN;
		endcase
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			state <= SRR_RUN;
		else
			state <= next_state;
	end

	// Processor status towards the core
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			cpu_idle_o <= 1'b0;
			resume_irq_o <= 1'b0;
			state_o <= SRR_RUN;
		end
		else
		begin
			// Idle holds until the resume interrupt is delivered
			cpu_idle_o <= (next_state == SRR_SUSPEND) ||
				(next_state == SRR_WAIT_CLK); // [R04]
			resume_irq_o <= (next_state == SRR_RESUME); // [R08]
			state_o <= next_state;
		end
	end

	// Clock stop; a captured wake clears it with no clock running
	always_ff @(posedge clk_i or posedge wake_any)
	begin
		if (wake_any)
			osc_stop_o <= 1'b0; // [R07]
		else if (rst_i)
			osc_stop_o <= 1'b0;
		else if (state == SRR_SUSPEND && wake_clr)
			osc_stop_o <= 1'b1; // [R05] one edge late, so the clear is gone
	end

	// Stale wakes are dropped on entry; captured ones after resume starts
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			wake_clr <= 1'b1;
		else
			wake_clr <= pd_req || (state == SRR_WAIT_CLK && stab_s);
	end

	// Power control register; power-down bit drops once awake
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			power_control_sfr <= `SRR_SFR_RESET;
		else if (wr_pc && state == SRR_RUN)
			power_control_sfr <= sfr_wdata_i; // [R10]
		else if (state == SRR_RESUME)
			power_control_sfr[`SRR_PD_BIT] <= 1'b0; // [R09]
	end

	// Extended flags for lines two to five; set beats a firmware clear
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			ext_int_flags <= 4'h0;
		else
		begin
			if (wr_fl)
				ext_int_flags <= sfr_wdata_i[`SRR_FLAGS_LSB +: 4]; // [R11]
			if (usb_interrupt_request_o && !usb_req_d)
				ext_int_flags[0] <= 1'b1;
			if (ext_evt_i[0])
				ext_int_flags[1] <= 1'b1;
			if (ext_evt_i[1])
				ext_int_flags[2] <= 1'b1;
			if (ext_evt_i[2])
				ext_int_flags[3] <= 1'b1;
		end
	end

	// Control register: line six flag, wakeup flag and enable
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			ext_int_control <= `SRR_SFR_RESET;
		else
		begin
			if (wr_ct)
				ext_int_control <= sfr_wdata_i;
			if (ext_evt_i[3])
				ext_int_control[`SRR_X6_FLAG_BIT] <= 1'b1; // [R12]
			if (state == SRR_SUSPEND && rw_s && !wake_clr)
				ext_int_control[`SRR_WAKE_FLAG_BIT] <= 1'b1; // [R13]
		end
	end

	// Enables and priorities
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ext_int_enables <= `SRR_SFR_RESET;
			ext_int_priority <= `SRR_SFR_RESET;
		end
		else
		begin
			if (wr_en)
				ext_int_enables <= sfr_wdata_i; // [R11] [R12]
			if (wr_pr)
				ext_int_priority <= sfr_wdata_i; // [R11] [R12]
		end
	end

	// Gated requests and priorities to the interrupt controller
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ext_irq_o <= 5'h00;
			ext_prio_o <= 5'h00;
			wake_irq_o <= 1'b0;
		end
		else
		begin
			ext_irq_o <= {ext_int_control[`SRR_X6_FLAG_BIT], ext_int_flags} &
				ext_int_enables[4:0]; // [R11] [R12]
			ext_prio_o <= ext_int_priority[4:0];
			wake_irq_o <= ext_int_control[`SRR_WAKE_FLAG_BIT] &
				ext_int_control[`SRR_WAKE_EN_BIT]; // [R13]
		end
	end

	// Registered read data for the addressed register
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			sfr_rdata_o <= 8'h00;
		else
		begin
			case (sfr_addr_i)
				`SRR_ADDR_POWER_CONTROL: sfr_rdata_o <= power_control_sfr;
				`SRR_ADDR_FLAGS: sfr_rdata_o <= {ext_int_flags, 4'h0};
				`SRR_ADDR_CONTROL: sfr_rdata_o <= ext_int_control;
				`SRR_ADDR_ENABLES: sfr_rdata_o <= ext_int_enables;
				`SRR_ADDR_PRIORITY: sfr_rdata_o <= ext_int_priority;
				default: sfr_rdata_o <= 8'h00;
			endcase
		end
	end

	// Strap settles through the synchroniser before it is trusted
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			strap_cnt <= 2'h0;
		else if (strap_cnt != `SRR_STRAP_WAIT)
			strap_cnt <= strap_cnt + 2'h1;
	end

	// Processor reset: held from power-up, released by host or strap
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			cpu_reset_o <= 1'b1; // [R14] [R15]
		else if (host_reset_we_i)
			cpu_reset_o <= host_reset_bit_i; // [R14] [R15]
		else if (strap_cnt == `SRR_STRAP_WAIT - 2'h1 && boot_s)
			cpu_reset_o <= 1'b0; // [R16]
	end

endmodule : srr_power_ctrl

/* verif/srr_osc_model.sv */
// Oscillator and PLL model for the clock generator.
// Assumes osc_stop_i comes straight from the controller.
module srr_osc_model #(
	parameter int STABLE_NS = 200
) (
	// Stop request
	input wire logic osc_stop_i,
	// Lock flag
	output logic clk_stable_o
);
	timeunit 1ns;
	timeprecision 100ps;
	initial clk_stable_o = 1'b1;
	// Lock is lost the moment the oscillator stops
	always @(posedge osc_stop_i)
		clk_stable_o = 1'b0;
	// Lock comes back only after the settle time
	always @(negedge osc_stop_i)
	begin
		#STABLE_NS;
		clk_stable_o = !osc_stop_i;
	end
endmodule : srr_osc_model

/* verif/srr_power_ctrl_assertions.sv */
// Port checker for the power controller.
// Assumes a bind to srr_power_ctrl; one clock domain.
`include "srr_defs.svh"
module srr_power_ctrl_assertions
	import srr_pkg::*;
#(
	parameter int SUSPEND_CYCLES = `SRR_SUSP_IDLE_CYC,
	parameter int USB_SOURCES = `SRR_USB_SOURCES
) (
	// Inputs watched
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [7:0] sfr_addr_i,
	input wire logic sfr_wr_i,
	input wire logic [7:0] sfr_wdata_i,
	input wire logic bus_activity_i,
	input wire logic clk_stable_i,
	input wire logic boot_nvm_i,
	input wire logic [USB_SOURCES-2:0] usb_src_i,
	input wire logic resume_ack_i,
	input wire logic host_reset_we_i,
	input wire logic host_reset_bit_i,
	// Outputs watched
	input wire logic usb_interrupt_request_o,
	input wire logic resume_irq_o,
	input wire logic cpu_idle_o,
	input wire logic osc_stop_o,
	input wire logic cpu_reset_o,
	input wire logic [3:0] state_o
);
	int idle_cnt;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// Idle cycles since bus activity, saturating
	always_ff @(posedge clk_i)
	begin
		if (rst_i || bus_activity_i)
			idle_cnt <= 0;
		else if (idle_cnt < SUSPEND_CYCLES)
			idle_cnt <= idle_cnt + 1;
	end
	sequence s_pd_write;
		state_o == SRR_RUN && sfr_wr_i && sfr_addr_i == `SRR_ADDR_POWER_CONTROL
			&& sfr_wdata_i[0];
	endsequence
	sequence s_unstable;
		(state_o == SRR_WAIT_CLK && !clk_stable_i) [*2];
	endsequence
	a_pd_suspends: assert property (s_pd_write |=> state_o == SRR_SUSPEND && cpu_idle_o)
		else $error("power-down write did not suspend");
	a_stop_in_susp: assert property (@(posedge osc_stop_o) state_o == SRR_SUSPEND && cpu_idle_o)
		else $error("oscillator stopped outside suspend");
	a_idle_state: assert property (cpu_idle_o == (state_o == SRR_SUSPEND || state_o == SRR_WAIT_CLK))
		else $error("idle flag disagrees with state");
	a_resume_level: assert property (resume_irq_o == (state_o == SRR_RESUME))
		else $error("resume interrupt disagrees with state");
	a_unstable_hold: assert property (s_unstable |=> state_o != SRR_RESUME)
		else $error("resume before clocks stable");
	a_ack_to_run: assert property (state_o == SRR_RESUME && resume_ack_i |=> state_o == SRR_RUN)
		else $error("resume ack did not return to run");
	a_usb_share: assert property (usb_src_i != '0 |=> usb_interrupt_request_o)
		else $error("usb source not on shared line");
	a_suspend_time: assert property ($rose(usb_interrupt_request_o) && $past(usb_src_i) == '0
		|-> idle_cnt >= SUSPEND_CYCLES)
		else $error("suspend flagged too early");
	a_host_reset: assert property (host_reset_we_i |=> cpu_reset_o == $past(host_reset_bit_i))
		else $error("cpu reset ignores host bit");
	a_reset_held: assert property (!boot_nvm_i && !host_reset_we_i && cpu_reset_o |=> cpu_reset_o)
		else $error("cpu reset released on its own");
	a_wake_restart: assert property (!osc_stop_o && state_o == SRR_SUSPEND
		|-> ##[0:6] state_o == SRR_WAIT_CLK)
		else $error("wake did not restart sequence");
endmodule : srr_power_ctrl_assertions

/* verif/srr_power_ctrl_tb.sv */
// Self-checking bench for the power controller.
// Assumes the oscillator model beside it; clock halts while stopped.
module srr_power_ctrl_tb;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int SUSP = 50;
	logic clk = 0, rst = 1, wr = 0, bus = 1, wake_n = 1, nvm = 0;
	logic sack = 0, rack = 0, hwe = 0, hbit = 0;
	logic [7:0] addr = '0, wdata = '0;
	logic [19:0] src = '0;
	logic [3:0] evt = '0;
	logic [7:0] rdata;
	logic [4:0] xirq, xprio;
	logic uirq, wirq, rirq, idle, ostop, creset, stable;
	logic [3:0] state;
	int mismatches = 0, n_checks = 0, n;
	// Clock parks low while the oscillator is stopped
	always #2 if (ostop !== 1'b1 || clk) clk = ~clk;
	srr_power_ctrl #(.SUSPEND_CYCLES(SUSP)) u_dut (.clk_i(clk), .rst_i(rst),
		.sfr_addr_i(addr), .sfr_wr_i(wr), .sfr_wdata_i(wdata), .sfr_rdata_o(rdata),
		.bus_activity_i(bus), .wakeup_n_i(wake_n), .clk_stable_i(stable),
		.boot_nvm_i(nvm), .usb_src_i(src), .suspend_ack_i(sack), .ext_evt_i(evt),
		.resume_ack_i(rack), .host_reset_we_i(hwe), .host_reset_bit_i(hbit),
		.usb_interrupt_request_o(uirq), .ext_irq_o(xirq), .ext_prio_o(xprio),
		.wake_irq_o(wirq), .resume_irq_o(rirq), .cpu_idle_o(idle), .osc_stop_o(ostop),
		.cpu_reset_o(creset), .state_o(state));
	srr_osc_model u_osc (.osc_stop_i(ostop), .clk_stable_o(stable));
	task automatic test_done();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : test_done
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	function automatic logic sig(input int k);
		case (k)
			0: return uirq;
			1: return rirq;
			2: return !creset;
			default: return xirq[4:1] == 4'hf;
		endcase
	endfunction : sig
	// Bounded wait; a miss ends the run
	task automatic await(input int k, input int lim, output int cnt);
		for (cnt = 0; cnt < lim && sig(k) !== 1'b1; cnt++)
			@(posedge clk) #1;
		if (sig(k) !== 1'b1)
		begin
			mismatches++;
			$display("[FAIL] wait %0d expected 1 seen 0", k);
			test_done();
		end
	endtask : await
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(negedge clk) addr = a;
		@(posedge clk) #1 check("sfr read", rdata, exp);
	endtask : rd
	task automatic wreg(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		addr = a;
		wdata = d;
		wr = 1'b1;
		@(negedge clk) wr = 1'b0;
	endtask : wreg
	task automatic t_reset();
		repeat (5) @(posedge clk);
		#1 check("cpu reset", creset, 1);
		rd(8'h87, 8'h00);
		rd(8'h91, 8'h00);
		rd(8'hd8, 8'h00);
		rd(8'he8, 8'h00);
		rd(8'hf8, 8'h00);
		rd(8'h90, 8'h00);
		$display("test reset done");
	endtask : t_reset
	task automatic t_usb_share();
		@(negedge clk) src = 20'h00020;
		await(0, 3, n);
		@(negedge clk) src = '0;
		rd(8'h91, 8'h10);
		check("request", uirq, 0);
		wreg(8'h91, 8'h00);
		$display("test usb share done");
	endtask : t_usb_share
	task automatic t_ext_irq();
		wreg(8'he8, 8'h1f);
		wreg(8'hf8, 8'h1f);
		rd(8'he8, 8'h1f);
		check("prio", xprio, 8'h1f);
		@(negedge clk) evt = 4'hf;
		@(negedge clk) evt = 4'h0;
		await(3, 5, n);
		check("irq line2", xirq[0], 0);
		rd(8'h91, 8'he0);
		rd(8'hd8, 8'h08);
		wreg(8'hd8, 8'h00);
		wreg(8'h91, 8'h00);
		$display("test ext irq done");
	endtask : t_ext_irq
	task automatic t_suspend();
		@(negedge clk) bus = 1'b0;
		await(0, SUSP + 20, n);
		check("idle wait", n >= SUSP, 1);
		@(negedge clk) sack = 1'b1;
		@(negedge clk) sack = 1'b0;
		rd(8'h91, 8'h10);
		wreg(8'h91, 8'h00);
		check("request", uirq, 0);
		$display("test suspend done");
	endtask : t_suspend
	task automatic t_bus_wake();
		wreg(8'h87, 8'h01);
		#100 check("idle", idle, 1);
		check("osc stop", ostop, 1);
		check("clock", clk, 0);
		bus = 1'b1;
		#1 check("osc stop", ostop, 0);
		check("stable", stable, 0);
		await(1, 200, n);
		check("stable", stable, 1);
		check("idle", idle, 0);
		@(negedge clk) rack = 1'b1;
		@(negedge clk) rack = 1'b0;
		check("state", state, 8'h01);
		rd(8'h87, 8'h00);
		$display("test bus wake done");
	endtask : t_bus_wake
	task automatic t_pin_wake();
		wreg(8'h87, 8'h01);
		#100 wake_n = 1'b0;
		#20 wake_n = 1'b1;
		await(1, 200, n);
		@(negedge clk) rack = 1'b1;
		@(negedge clk) rack = 1'b0;
		rd(8'hd8, 8'h10);
		wreg(8'hd8, 8'h30);
		@(posedge clk) #1 check("wake irq", wirq, 1);
		$display("test pin wake done");
	endtask : t_pin_wake
	task automatic t_host_boot();
		@(negedge clk);
		hwe = 1'b1;
		hbit = 1'b0;
		@(negedge clk) hwe = 1'b0;
		check("cpu reset", creset, 0);
		@(negedge clk);
		hwe = 1'b1;
		hbit = 1'b1;
		@(negedge clk) hwe = 1'b0;
		check("cpu reset", creset, 1);
		nvm = 1'b1;
		rst = 1'b1;
		repeat (4) @(negedge clk);
		rst = 1'b0;
		await(2, 10, n);
		check("boot edges", n, 3);
		$display("test host boot done");
	endtask : t_host_boot
	// Hang guard
	initial
	begin
		#200us;
		mismatches++;
		test_done();
	end
	// Main sequence
	initial
	begin
		repeat (20) @(negedge clk);
		rst = 1'b0;
		t_reset();
		t_usb_share();
		t_ext_irq();
		t_suspend();
		t_bus_wake();
		t_pin_wake();
		t_host_boot();
		test_done();
	end
endmodule : srr_power_ctrl_tb

bind srr_power_ctrl srr_power_ctrl_assertions #(.SUSPEND_CYCLES(SUSPEND_CYCLES),
	.USB_SOURCES(USB_SOURCES)) u_chk (.clk_i(clk_i), .rst_i(rst_i),
	.sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i), .sfr_wdata_i(sfr_wdata_i),
	.bus_activity_i(bus_activity_i), .clk_stable_i(clk_stable_i),
	.boot_nvm_i(boot_nvm_i), .usb_src_i(usb_src_i), .resume_ack_i(resume_ack_i),
	.host_reset_we_i(host_reset_we_i), .host_reset_bit_i(host_reset_bit_i),
	.usb_interrupt_request_o(usb_interrupt_request_o), .resume_irq_o(resume_irq_o),
	.cpu_idle_o(cpu_idle_o), .osc_stop_o(osc_stop_o), .cpu_reset_o(cpu_reset_o),
	.state_o(state_o));
